// [ext_mode_config.sv]
// extended mode register and dll control of a ddr memory device
// commands arrive already decoded on the memory clock from a controller
// What this block does
// - bank bit1 low, bit0 high loads extended register
// - settings hold until next extended load; self refresh exit changes only dll enable
// - self refresh exit re-enables dll
// - drive strength normal or reduced selectable
`timescale 1ns/1ps
`default_nettype none
`include "ext_mode_defines.svh"

module ext_mode_config #(
	parameter int unsigned SETTLE_CYC = `DLL_SETTLE_CYC,
	parameter int unsigned LOAD_CYC   = `MODE_LOAD_CYC
) (
	input  wire logic                              sys_clk_i,
	input  wire logic                              rst_n_i,
	input  wire ext_mode_pkg::mode_load_command_s  cmd_i,
	input  wire logic                              exec_cmd_i,
	input  wire logic                              self_refresh_exit_i,
	output logic                                   dll_enable_o,
	output logic                                   drive_strength_select_o,
	output logic                                   dll_locked_o,
	output logic                                   load_busy_o,
	output logic                                   early_cmd_o,
	output logic                                   reserved_write_o
);

	logic rst_meta_q;
	logic rst_sync_q;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// command decode; only mode loads travel on cmd_i
	logic ext_load;
	logic base_load;
	logic dll_rst_req;
	logic dll_rst_clr;

	always_comb begin
		ext_load    = 1'b0;
		base_load   = 1'b0;
		dll_rst_req = 1'b0;
		dll_rst_clr = 1'b0;
		if (cmd_i.valid && !cmd_i.bank_select_bit1) begin
			ext_load  = cmd_i.bank_select_bit0;
			base_load = !cmd_i.bank_select_bit0;
		end
		if (base_load) begin
			dll_rst_req = cmd_i.addr[`DLL_RESET_BIT];
			dll_rst_clr = !cmd_i.addr[`DLL_RESET_BIT];
		end
	end

	// extended configuration register
	ext_mode_pkg::extended_config_register_s ecr_q;
	ext_mode_pkg::extended_config_register_s ecr_d;

	always_comb begin
		ecr_d = ecr_q;
		if (ext_load) begin
			ecr_d.dll_enable            = !cmd_i.addr[`DLL_DISABLE_BIT];
			ecr_d.drive_strength_select = cmd_i.addr[`DRIVE_SEL_BIT];
		end
		// self refresh exit wins over a disabling load in the same cycle
		if (self_refresh_exit_i) begin
			ecr_d.dll_enable = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			// normal strength, dll enabled until the first load
			ecr_q <= '{dll_enable: 1'b1, drive_strength_select: 1'b0};
		end else begin
			ecr_q <= ecr_d;
		end
	end

	// reserved bit flag, one cycle per offending load
	logic reserved_q;
	logic reserved_d;

	always_comb begin
		reserved_d = 1'b0;
		if (ext_load) begin
			reserved_d = |(cmd_i.addr & `RESERVED_MASK);
		end else if (base_load) begin
			reserved_d = |(cmd_i.addr & `MR_RESERVED_MASK);
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			reserved_q <= 1'b0;
		end else begin
			reserved_q <= reserved_d;
		end
	end

	// dll lock state
	ext_mode_pkg::dll_state_e st_q;
	ext_mode_pkg::dll_state_e st_d;
	logic                     rst_seen_q;
	logic                     rst_seen_d;
	logic                     dll_en_evt;
	logic                     settle_load;
	logic                     settle_busy;

	// any extended load that leaves the dll enabled counts as enabling it,
	// so the enabled reset default cannot skip the reset step
	assign dll_en_evt = ecr_d.dll_enable && (ext_load || !ecr_q.dll_enable);

	always_comb begin
		st_d        = st_q;
		rst_seen_d  = rst_seen_q;
		settle_load = 1'b0;
		unique case (st_q)
			ext_mode_pkg::DLL_OFF: begin
				if (self_refresh_exit_i) begin
					// dll restarts by itself, settle starts at once
					settle_load = 1'b1;
					rst_seen_d  = 1'b1;
					st_d        = ext_mode_pkg::DLL_WAIT_RS;
				end else if (dll_en_evt) begin
					rst_seen_d = 1'b0;
					st_d       = ext_mode_pkg::DLL_WAIT_RS;
				end
			end
			ext_mode_pkg::DLL_WAIT_RS: begin
				if (!ecr_d.dll_enable) begin
					rst_seen_d = 1'b0;
					st_d       = ext_mode_pkg::DLL_OFF;
				end else if (dll_rst_req) begin
					settle_load = 1'b1;
					rst_seen_d  = 1'b1;
				end else if (rst_seen_q && !settle_busy && dll_rst_clr) begin
					// lock needs a reset, the full settle and the reset bit cleared
					rst_seen_d = 1'b0;
					st_d       = ext_mode_pkg::DLL_LOCKED;
				end
			end
			ext_mode_pkg::DLL_LOCKED: begin
				if (!ecr_d.dll_enable) begin
					st_d = ext_mode_pkg::DLL_OFF;
				end else if (dll_rst_req) begin
					settle_load = 1'b1;
					rst_seen_d  = 1'b1;
					st_d        = ext_mode_pkg::DLL_WAIT_RS;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			st_q       <= ext_mode_pkg::DLL_OFF;
			rst_seen_q <= 1'b0;
		end else begin
			st_q       <= st_d;
			rst_seen_q <= rst_seen_d;
		end
	end

	settle_counter #(
		.WIDTH(`SETTLE_CNT_W)
	) u_settle (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_sync_q),
		.load_i    (settle_load),
		.load_val_i(`SETTLE_CNT_W'(SETTLE_CYC)),
		.busy_o    (settle_busy)
	);

	// gap after a mode load, and commands that break it or the settle
	logic [1:0] gap_q;
	logic [1:0] gap_d;
	logic       early_q;
	logic       early_d;

	always_comb begin
		gap_d   = (gap_q != 2'h0) ? gap_q - 2'h1 : 2'h0;
		early_d = 1'b0;
		if (gap_q != 2'h0 && (cmd_i.valid || exec_cmd_i)) begin
			early_d = 1'b1;
		end
		if (settle_busy && exec_cmd_i) begin
			early_d = 1'b1;
		end
		// a load restarts the gap even if it came too early itself
		if (ext_load || base_load) begin
			gap_d = 2'(LOAD_CYC - 1);
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			gap_q   <= 2'h0;
			early_q <= 1'b0;
		end else begin
			gap_q   <= gap_d;
			early_q <= early_d;
		end
	end

	assign dll_enable_o            = ecr_q.dll_enable;
	assign drive_strength_select_o = ecr_q.drive_strength_select;
	assign dll_locked_o            = (st_q == ext_mode_pkg::DLL_LOCKED);
	assign load_busy_o             = (gap_q != 2'h0) || settle_busy;
	assign early_cmd_o             = early_q;
	assign reserved_write_o        = reserved_q;

endmodule
`default_nettype wire

// [ext_mode_defines.svh]
// constants for the extended mode / dll configuration block
// assumes a 100 MHz command clock; included by bare name
`ifndef EXT_MODE_DEFINES_SVH
`define EXT_MODE_DEFINES_SVH

`define ADDR_W           13
`define CLK_PERIOD_NS    10
`define DLL_DISABLE_BIT  0
`define DRIVE_SEL_BIT    1
`define DLL_RESET_BIT    8
`define DLL_SETTLE_CYC   200
`define MODE_LOAD_CYC    2
`define SETTLE_CNT_W     8
`define SETTLE_CNT_ZERO  8'h00
`define SETTLE_CNT_MAX   8'hc8
`define RESERVED_MASK    13'h1ffc
`define MR_RESERVED_MASK 13'h1e80

`endif

// [ext_mode_pkg.sv]
// types for the extended mode / dll configuration block
// no surroundings assumed
package ext_mode_pkg;

	typedef struct packed {
		logic       valid;
		logic       bank_select_bit1;
		logic       bank_select_bit0;
		logic [12:0] addr;
	} mode_load_command_s;

	typedef struct packed {
		logic dll_enable;
		logic drive_strength_select;
	} extended_config_register_s;

	typedef enum logic [2:0] {
		DLL_OFF     = 3'b001,
		DLL_WAIT_RS = 3'b010,
		DLL_LOCKED  = 3'b100
	} dll_state_e;

endpackage

// [settle_counter.sv]
// down counter that marks the dll settling window
// same clock and synchronised reset as the parent
`timescale 1ns/1ps
`default_nettype none
`include "ext_mode_defines.svh"

module settle_counter #(
	parameter int unsigned WIDTH = `SETTLE_CNT_W
) (
	input  wire logic             sys_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             load_i,
	input  wire logic [WIDTH-1:0] load_val_i,
	output logic                  busy_o
);

	logic [WIDTH-1:0] cnt_q;
	logic [WIDTH-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (load_i) begin
			cnt_d = load_val_i;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - WIDTH'(1);
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign busy_o = (cnt_q != '0);

endmodule
`default_nettype wire

// [ext_mode_config_monitor.sv]
// assertions on the extended mode block ports
// bound to every ext_mode_config instance
`timescale 1ns/1ps
`default_nettype none
module ext_mode_config_monitor #(parameter int unsigned SETTLE_CYC = 200) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire ext_mode_pkg::mode_load_command_s cmd_i,
	input wire logic exec_cmd_i,
	input wire logic self_refresh_exit_i,
	input wire logic dll_enable_o,
	input wire logic drive_strength_select_o,
	input wire logic dll_locked_o,
	input wire logic load_busy_o,
	input wire logic early_cmd_o,
	input wire logic reserved_write_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire logic ext = cmd_i.valid && !cmd_i.bank_select_bit1 && cmd_i.bank_select_bit0;
	wire logic dll_rst = cmd_i.valid && !cmd_i.bank_select_bit1 && !cmd_i.bank_select_bit0 && cmd_i.addr[8];
	logic [7:0] cnt_q;
	sequence too_soon_s;
		cmd_i.valid ##1 (cmd_i.valid || exec_cmd_i);
	endsequence
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
		if (!rst_n_i) cnt_q <= 8'h00;
		else if (dll_rst && dll_enable_o) cnt_q <= 8'(SETTLE_CYC);
		else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
	ext_load_a: assert property (ext |=> dll_enable_o == !$past(cmd_i.addr[0])) else $error("dll enable");
	drive_sel_a: assert property (ext |=> drive_strength_select_o == $past(cmd_i.addr[1])) else $error("drive");
	cfg_hold_a: assert property (!ext |=> $stable(drive_strength_select_o)) else $error("drive moved");
	sr_exit_a: assert property (self_refresh_exit_i && !cmd_i.valid |=> dll_enable_o) else $error("sr exit");
	rsv_flag_a: assert property (ext |=> reserved_write_o == |$past(cmd_i.addr[12:2])) else $error("rsv");
	early_flag_a: assert property (too_soon_s |=> early_cmd_o) else $error("early");
	settle_busy_a: assert property (cnt_q != 8'h00 |-> load_busy_o) else $error("settle");
	lock_cause_a: assert property ($rose(dll_locked_o) |-> $past(dll_rst) == 1'b0 && $past(cmd_i.valid)) else $error("lock");
	lock_dll_a: assert property (dll_locked_o |-> dll_enable_o) else $error("lock off");
endmodule
bind ext_mode_config ext_mode_config_monitor #(.SETTLE_CYC(SETTLE_CYC)) mon (
	.sys_clk_i(sys_clk_i),
	.rst_n_i(rst_n_i),
	.cmd_i(cmd_i),
	.exec_cmd_i(exec_cmd_i),
	.self_refresh_exit_i(self_refresh_exit_i),
	.dll_enable_o(dll_enable_o),
	.drive_strength_select_o(drive_strength_select_o),
	.dll_locked_o(dll_locked_o),
	.load_busy_o(load_busy_o),
	.early_cmd_o(early_cmd_o),
	.reserved_write_o(reserved_write_o)
);
`default_nettype wire

// [ddr_ctrl_model.sv]
// controller side: mode loads, executable commands, self refresh exit
// released bus shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module ddr_ctrl_model (
	input wire logic sys_clk_i,
	output var ext_mode_pkg::mode_load_command_s cmd_o,
	output var logic exec_o,
	output var logic sr_o
);
	initial begin
		cmd_o = '0;
		exec_o = 1'b0;
		sr_o = 1'b0;
	end
	// no bursts ever run, so banks are idle at each load
	task automatic load(input logic [1:0] ba, input logic [12:0] a);
		@(posedge sys_clk_i) #1;
		cmd_o = {1'b1, ba, a};
		@(posedge sys_clk_i) #1;
		cmd_o = {1'b0, ~ba, ~a};
	endtask
	task automatic pulse_exec;
		exec_o = 1'b1;
		@(posedge sys_clk_i) #1;
		exec_o = 1'b0;
	endtask
	task automatic sr_exit;
		@(posedge sys_clk_i) #1;
		sr_o = 1'b1;
		@(posedge sys_clk_i) #1;
		sr_o = 1'b0;
	endtask
endmodule
`default_nettype wire

// [ext_mode_config_tb.sv]
// self-checking bench for ext_mode_config
// settle count shortened to 5 cycles
`timescale 1ns/1ps
`default_nettype none
module ext_mode_config_tb;
	localparam int unsigned SETTLE = 5;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	ext_mode_pkg::mode_load_command_s cmd;
	logic exec, sr, en, drv, lck, busy, early, rsv;
	int bad_count = 0;
	int comparisons = 0;
	ddr_ctrl_model ctl (.sys_clk_i(sys_clk_i), .cmd_o(cmd), .exec_o(exec), .sr_o(sr));
	ext_mode_config #(.SETTLE_CYC(SETTLE)) dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd),
		.exec_cmd_i(exec), .self_refresh_exit_i(sr), .dll_enable_o(en), .drive_strength_select_o(drv),
		.dll_locked_o(lck), .load_busy_o(busy), .early_cmd_o(early), .reserved_write_o(rsv));
	initial forever #5 sys_clk_i = ~sys_clk_i;
	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#20000;
		bad_count++;
		end_of_test();
	end
	initial begin
		repeat (12) @(posedge sys_clk_i);
		#1 rst_n_i = 1'b1;
		repeat (3) @(posedge sys_clk_i);
		#1;
		check({en, drv, lck, busy}, 4'h8);
		ctl.load(2'b01, 13'h0002);
		check({en, drv, lck, busy}, 4'hd);
		ctl.load(2'b01, 13'h0001);
		check({en, drv, lck, busy}, 4'h1);
		ctl.load(2'b00, 13'h0002);
		check({en, drv, lck, busy}, 4'h1);
		ctl.pulse_exec();
		check({2'b00, early, rsv}, 4'h2);
		$display("test config done");
		ctl.sr_exit();
		check({en, drv, lck, busy}, 4'h9);
		ctl.pulse_exec();
		check({2'b00, early, rsv}, 4'h2);
		repeat (SETTLE) @(posedge sys_clk_i);
		ctl.load(2'b01, 13'h0001);
		ctl.load(2'b01, 13'h0000);
		ctl.load(2'b00, 13'h0000);
		check({en, drv, lck, busy}, 4'h9);
		ctl.load(2'b00, 13'h0100);
		check({en, drv, lck, busy}, 4'h9);
		repeat (SETTLE) @(posedge sys_clk_i);
		ctl.load(2'b00, 13'h0000);
		check({en, drv, lck, busy}, 4'hb);
		$display("test dll done");
		ctl.load(2'b01, 13'h0004);
		check({2'b00, early, rsv}, 4'h1);
		ctl.load(2'b00, 13'h0080);
		check({2'b00, early, rsv}, 4'h1);
		$display("test reserved done");
		end_of_test();
	end
endmodule
`default_nettype wire
